//--- hw/gdp_deglitch.sv
`timescale 1ns/1ps
// Level changes only after the raw input has held its new value for CYCLES clocks
module gdp_deglitch #(
  parameter int   CYCLES = gdp_pkg::UVLO_DEGLITCH_CYCLES,
  parameter logic INIT   = gdp_pkg::LOCKOUT_RESET
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      level
);

  gdp_pkg::gdp_glitch_s s, next_s;

  always_comb begin
    next_s = s;
    if (raw == s.level) begin
      next_s.cnt = '0;
    end else if (s.cnt == gdp_pkg::CNT_W'(CYCLES - 1)) begin
      next_s.level = raw;
      next_s.cnt   = '0;
    end else begin
      next_s.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s.level <= INIT;
      s.cnt   <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A dip shorter than the filter never moves the level
  property p_short_dip;
    $changed(level) |-> $past(raw, 1) == level
                        && $past(s.cnt, 1) == gdp_pkg::CNT_W'(CYCLES - 1);
  endproperty
  a_short_dip: assert property (p_short_dip) else $error("deglitch flipped on unsettled input");

endmodule // gdp_deglitch

//--- hw/gdp_pkg.sv
package gdp_pkg;

  // Clock: 20 MHz
  localparam int CLK_PERIOD_NS = 50;

  // Supply lockout deglitch width
  localparam int UVLO_DEGLITCH_NS = 5000;
  localparam int UVLO_DEGLITCH_CYCLES = (UVLO_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Mid-level hold time of the two-level turn-off
  localparam int MID_HOLD_NS = 1000;
  localparam int MID_HOLD_CYCLES = (MID_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Low time of reset/enable that must be exceeded to count as a fault reset
  localparam int RST_FILTER_NS = 1000;
  localparam int RST_FILTER_CYCLES = (RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Fault mute time; its cycle count is a top-level parameter
  localparam int FAULT_MUTE_NS = 500000;
  localparam int FAULT_MUTE_CYCLES = (FAULT_MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 16;
  localparam int LOW_W = 8;

  // Reset values
  localparam logic LOCKOUT_RESET = 1'b1;
  localparam logic FAULT_RESET = 1'b0;

  typedef enum logic [1:0] {
    GDP_OFF_IDLE = 2'b00,
    GDP_OFF_MID  = 2'b01,
    GDP_OFF_SOFT = 2'b10
  } gdp_off_e;

  typedef struct packed {
    logic             level;
    logic [CNT_W-1:0] cnt;
  } gdp_glitch_s;

  typedef struct packed {
    gdp_off_e         state;
    logic [CNT_W-1:0] cnt;
  } gdp_off_s;

  typedef struct packed {
    logic             gate_on;
    logic             fault;
    logic [CNT_W-1:0] mute_cnt;
    logic [LOW_W-1:0] low_cnt;
    logic             rst_en_q;
    logic             clamp;
    logic             pwm;
  } gdp_ctl_s;

endpackage

//--- hw/gdp_protect.sv
`timescale 1ns/1ps
module gdp_protect #(
  parameter int MUTE_CYCLES = gdp_pkg::FAULT_MUTE_CYCLES,
  parameter int HOLD_CYCLES = gdp_pkg::MID_HOLD_CYCLES,
  parameter int GLITCH_CYCLES = gdp_pkg::UVLO_DEGLITCH_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic vcc_uvlo_raw,
  input  wire logic vdd_uvlo_raw,
  input  wire logic vdd_open,
  input  wire logic in_pos,
  input  wire logic in_neg,
  input  wire logic inputs_floating,
  input  wire logic enable_rst_n,
  input  wire logic overcurrent_trip,
  input  wire logic overcurrent_sense_in,
  input  wire logic gate_below_clamp,
  input  wire logic gate_at_rail,
  input  wire logic analog_sense_input,
  output logic      gate_output,
  output logic      gate_hard_sink,
  output logic      gate_mid_level,
  output logic      gate_soft_sink,
  output logic      gate_active_pulldown,
  output logic      miller_clamp_enable,
  output logic      overcurrent_sense_o,
  output logic      overcurrent_sense_oe,
  output logic      fault_report_n_o,
  output logic      fault_report_n_oe,
  output logic      power_good_o,
  output logic      power_good_oe,
  output logic      sensed_pwm_output
);

  gdp_pkg::gdp_ctl_s s, next_s;

  logic vcc_lock;
  logic vdd_lock;
  logic lockout;
  logic trip;
  logic drive_req;
  logic rst_rise;
  logic reset_ok;
  logic seq_abort;
  logic seq_mid;
  logic seq_soft;

  // Output supply comparator already carries the 12V/800mV hysteresis
  gdp_deglitch #(
    .CYCLES (GLITCH_CYCLES),
    .INIT   (gdp_pkg::LOCKOUT_RESET)
  ) u_vcc_glitch (
    .sys_clk (sys_clk),
    .rst     (rst),
    .raw     (vcc_uvlo_raw),
    .level   (vcc_lock)
  );

  gdp_deglitch #(
    .CYCLES (GLITCH_CYCLES),
    .INIT   (gdp_pkg::LOCKOUT_RESET)
  ) u_vdd_glitch (
    .sys_clk (sys_clk),
    .rst     (rst),
    .raw     (vdd_uvlo_raw),
    .level   (vdd_lock)
  );

  // An open output supply bypasses the filter: nothing is left to switch on
  assign lockout = vcc_lock | vdd_lock | vdd_open;

  // Trip only counts while the gate is on and the sense pin is released
  assign trip = s.gate_on & overcurrent_trip;

  assign drive_req = enable_rst_n & in_pos & ~in_neg & ~inputs_floating;

  assign rst_rise = enable_rst_n & ~s.rst_en_q;
  assign reset_ok = rst_rise
                  & (s.low_cnt > gdp_pkg::LOW_W'(gdp_pkg::RST_FILTER_CYCLES))
                  & (s.mute_cnt == '0);

  // Lockout or disable overrides the sequence with the hard sink, or with the active pulldown when the output supply is open
  assign seq_abort = lockout | ~enable_rst_n;

  gdp_two_level_off #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_two_level (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .start        (trip),
    .abort        (seq_abort),
    .gate_at_rail (gate_at_rail),
    .mid_level    (seq_mid),
    .soft_sink    (seq_soft)
  );

  always_comb begin
    next_s = s;
    next_s.rst_en_q = enable_rst_n;
    if (enable_rst_n) begin
      next_s.low_cnt = '0;
    end else if (s.low_cnt != {gdp_pkg::LOW_W{1'b1}}) begin
      next_s.low_cnt = s.low_cnt + 8'h01;
    end
    if (s.mute_cnt != '0) begin
      next_s.mute_cnt = s.mute_cnt - 16'h0001;
    end
    // A new trip wins over a clear in the same cycle
    if (trip) begin
      next_s.fault    = 1'b1;
      next_s.mute_cnt = gdp_pkg::CNT_W'(MUTE_CYCLES);
    end else if (reset_ok) begin
      next_s.fault = 1'b0;
    end
    // Priority: lockout, fault, disable, inputs
    if (lockout) begin
      next_s.gate_on = 1'b0;
    end else if (s.fault || trip) begin
      next_s.gate_on = 1'b0;
    end else if (!enable_rst_n) begin
      next_s.gate_on = 1'b0;
    end else begin
      next_s.gate_on = drive_req;
    end
    next_s.clamp = gate_below_clamp & ~vdd_lock & ~vdd_open;
    next_s.pwm   = analog_sense_input & ~lockout;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s.gate_on  <= 1'b0;
      s.fault    <= gdp_pkg::FAULT_RESET;
      s.mute_cnt <= '0;
      s.low_cnt  <= '0;
      s.rst_en_q <= 1'b0;
      s.clamp    <= 1'b0;
      s.pwm      <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign gate_output          = s.gate_on;
  assign gate_mid_level       = seq_mid;
  assign gate_soft_sink       = seq_soft;
  assign gate_hard_sink       = ~s.gate_on & ~seq_mid & ~seq_soft & ~vdd_open;
  assign gate_active_pulldown = vdd_open;
  assign miller_clamp_enable  = s.clamp;
  assign overcurrent_sense_o  = 1'b0;
  // Pulldown discharges the sense node whenever the switch is off
  assign overcurrent_sense_oe = ~s.gate_on | inputs_floating;
  assign fault_report_n_o     = 1'b0;
  assign fault_report_n_oe    = s.fault;
  assign power_good_o         = 1'b0;
  assign power_good_oe        = lockout;
  assign sensed_pwm_output    = s.pwm;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_lock_low;
    lockout |=> !gate_output;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("gate high during lockout");

  property p_gate_cause;
    $rose(gate_output) |-> $past(!lockout && drive_req && !s.fault, 1);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate rose without cause");

  property p_pg;
    power_good_oe == lockout;
  endproperty
  a_pg: assert property (p_pg) else $error("power good mismatch");

  property p_pwm_low;
    lockout |=> !sensed_pwm_output;
  endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("sensed pwm active in lockout");

  property p_clamp;
    (gate_below_clamp && !vdd_lock && !vdd_open) |=> miller_clamp_enable;
  endproperty
  a_clamp: assert property (p_clamp) else $error("miller clamp not enabled");

  property p_oc_pd;
    !gate_output |-> overcurrent_sense_oe;
  endproperty
  a_oc_pd: assert property (p_oc_pd) else $error("sense pin released while gate low");

  sequence s_trip;
    gate_output && overcurrent_trip && !lockout && enable_rst_n;
  endsequence

  sequence s_two_level;
    (!gate_output && fault_report_n_oe && gate_mid_level) ##1 gate_mid_level;
  endsequence

  property p_trip_seq;
    s_trip |=> s_two_level;
  endproperty
  a_trip_seq: assert property (p_trip_seq) else $error("trip did not start two-level off");

  property p_fault_hold;
    (fault_report_n_oe && !reset_ok) |=> fault_report_n_oe && !gate_output;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without reset");

  property p_mute;
    (s.mute_cnt != '0 && !trip) |=> s.fault == $past(s.fault);
  endproperty
  a_mute: assert property (p_mute) else $error("fault cleared during mute");

  property p_clear;
    (reset_ok && !trip) |=> !fault_report_n_oe;
  endproperty
  a_clear: assert property (p_clear) else $error("valid reset did not clear fault");

  property p_disable;
    !enable_rst_n |=> !gate_output && !gate_mid_level && !gate_soft_sink;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not take regular off");

  property p_vdd_open;
    vdd_open |-> gate_active_pulldown && !gate_hard_sink;
  endproperty
  a_vdd_open: assert property (p_vdd_open) else $error("no pulldown with open supply");

  // Soft phase is only reached through the full mid-level hold
  property p_soft_entry;
    $rose(gate_soft_sink) |-> $past(gate_mid_level);
  endproperty
  a_soft_entry: assert property (p_soft_entry) else $error("soft sink without mid phase");

  property p_mid_exit;
    $fell(gate_mid_level) |-> gate_soft_sink || $past(seq_abort);
  endproperty
  a_mid_exit: assert property (p_mid_exit) else $error("mid phase ended without soft sink");

  property p_soft_stay;
    (gate_soft_sink && !gate_at_rail && !seq_abort) |=> gate_soft_sink;
  endproperty
  a_soft_stay: assert property (p_soft_stay) else $error("soft sink stopped above rail");

  property p_soft_end;
    (gate_soft_sink && gate_at_rail)
      |=> !gate_soft_sink && (gate_hard_sink || gate_active_pulldown);
  endproperty
  a_soft_end: assert property (p_soft_end) else $error("soft sink kept after rail");

  property p_trip_fault;
    (gate_output && overcurrent_trip) |=> fault_report_n_oe;
  endproperty
  a_trip_fault: assert property (p_trip_fault) else $error("trip not reported");

  property p_fault_cause;
    $rose(fault_report_n_oe) |-> $past(gate_output && overcurrent_trip);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without trip");

  property p_oc_release;
    (gate_output && !inputs_floating) |-> !overcurrent_sense_oe;
  endproperty
  a_oc_release: assert property (p_oc_release) else $error("sense pin held while gate on");

  // Clamp transistor has no supply to drive it from
  property p_clamp_off;
    (vdd_lock || vdd_open) |=> !miller_clamp_enable;
  endproperty
  a_clamp_off: assert property (p_clamp_off) else $error("clamp enabled without supply");

  property p_lock_sink;
    (lockout && !vdd_open) |=> gate_hard_sink || gate_active_pulldown;
  endproperty
  a_lock_sink: assert property (p_lock_sink) else $error("no sink during lockout");

  property p_gate_allow;
    (!lockout && !fault_report_n_oe && !trip && drive_req) |=> gate_output;
  endproperty
  a_gate_allow: assert property (p_gate_allow) else $error("gate held low without cause");

endmodule // gdp_protect

//--- hw/gdp_two_level_off.sv
`timescale 1ns/1ps
// Two-level turn-off sequencer: hold at mid level, then soft discharge to the rail
module gdp_two_level_off #(
  parameter int HOLD_CYCLES = gdp_pkg::MID_HOLD_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic gate_at_rail,
  output logic      mid_level,
  output logic      soft_sink
);

  gdp_pkg::gdp_off_s s, next_s;

  always_comb begin
    next_s = s;
    case (s.state)
      gdp_pkg::GDP_OFF_IDLE: begin
        if (start && !abort) begin
          next_s.state = gdp_pkg::GDP_OFF_MID;
          next_s.cnt   = '0;
        end
      end
      gdp_pkg::GDP_OFF_MID: begin
        if (abort) begin
          next_s.state = gdp_pkg::GDP_OFF_IDLE;
        end else if (s.cnt == gdp_pkg::CNT_W'(HOLD_CYCLES - 1)) begin
          next_s.state = gdp_pkg::GDP_OFF_SOFT;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end
      gdp_pkg::GDP_OFF_SOFT: begin
        if (abort || gate_at_rail) begin
          next_s.state = gdp_pkg::GDP_OFF_IDLE;
        end
      end
      default: next_s.state = gdp_pkg::GDP_OFF_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s.state <= gdp_pkg::GDP_OFF_IDLE;
      s.cnt   <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mid_level = (s.state == gdp_pkg::GDP_OFF_MID);
  assign soft_sink = (s.state == gdp_pkg::GDP_OFF_SOFT);

endmodule // gdp_two_level_off

//--- tb/gate_driver_protection_control_tb.sv
`timescale 1ns/1ps
module gate_driver_protection_control_tb;
  logic sys_clk, rst, vcc_uvlo_raw, vdd_uvlo_raw, vdd_open, in_pos, in_neg;
  logic inputs_floating, enable_rst_n, gate_below_clamp, gate_at_rail, analog_sense_input;
  logic oc_level, overcurrent_trip, overcurrent_sense_in, power_good, fault_report_n;
  logic gate_output, gate_hard_sink, gate_mid_level, gate_soft_sink, gate_active_pulldown;
  logic miller_clamp_enable, overcurrent_sense_o, overcurrent_sense_oe;
  logic fault_report_n_o, fault_report_n_oe, power_good_o, power_good_oe, sensed_pwm_output;
  int   err_count;
  int   tests_run;

  gdp_protect #(.MUTE_CYCLES(50)) u_gdp_protect (
    .sys_clk(sys_clk), .rst(rst), .vcc_uvlo_raw(vcc_uvlo_raw), .vdd_uvlo_raw(vdd_uvlo_raw),
    .vdd_open(vdd_open), .in_pos(in_pos), .in_neg(in_neg), .inputs_floating(inputs_floating),
    .enable_rst_n(enable_rst_n), .overcurrent_trip(overcurrent_trip),
    .overcurrent_sense_in(overcurrent_sense_in), .gate_below_clamp(gate_below_clamp),
    .gate_at_rail(gate_at_rail), .analog_sense_input(analog_sense_input),
    .gate_output(gate_output), .gate_hard_sink(gate_hard_sink),
    .gate_mid_level(gate_mid_level), .gate_soft_sink(gate_soft_sink),
    .gate_active_pulldown(gate_active_pulldown), .miller_clamp_enable(miller_clamp_enable),
    .overcurrent_sense_o(overcurrent_sense_o), .overcurrent_sense_oe(overcurrent_sense_oe),
    .fault_report_n_o(fault_report_n_o), .fault_report_n_oe(fault_report_n_oe),
    .power_good_o(power_good_o), .power_good_oe(power_good_oe),
    .sensed_pwm_output(sensed_pwm_output));

  gdp_host_model u_gdp_host_model (
    .power_good_o(power_good_o), .power_good_oe(power_good_oe),
    .fault_report_n_o(fault_report_n_o), .fault_report_n_oe(fault_report_n_oe),
    .overcurrent_sense_o(overcurrent_sense_o), .overcurrent_sense_oe(overcurrent_sense_oe),
    .oc_level(oc_level), .power_good(power_good), .fault_report_n(fault_report_n),
    .overcurrent_sense_in(overcurrent_sense_in), .overcurrent_trip(overcurrent_trip));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic exp, input logic seen);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Inputs set after cyc move 5 ns after the edge, so outputs are settled when sampled
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask

  task automatic set_raw(input int which, input logic v);
    if (which == 0) vcc_uvlo_raw = v;
    else vdd_uvlo_raw = v;
  endtask

  task automatic t_lockout();
    in_pos = 1'b1;
    analog_sense_input = 1'b1;
    cyc(2);
    check("power_good", 1'b0, power_good);
    check("gate_output", 1'b0, gate_output);
    check("sensed_pwm", 1'b0, sensed_pwm_output);
    cyc(105);
    check("power_good", 1'b1, power_good);
    check("gate_output", 1'b1, gate_output);
    check("sensed_pwm", 1'b1, sensed_pwm_output);
    $display("t_lockout done");
  endtask

  task automatic t_drive();
    check("sense_oe", 1'b0, overcurrent_sense_oe);
    inputs_floating = 1'b1;
    #1;
    check("sense_oe", 1'b1, overcurrent_sense_oe);
    inputs_floating = 1'b0;
    in_neg = 1'b1;
    cyc(1);
    check("gate_output", 1'b0, gate_output);
    check("sense_oe", 1'b1, overcurrent_sense_oe);
    check("hard_sink", 1'b1, gate_hard_sink);
    in_neg = 1'b0;
    cyc(1);
    check("gate_output", 1'b1, gate_output);
    $display("t_drive done");
  endtask

  task automatic t_uvlo();
    for (int i = 0; i < 2; i++) begin
      // Two dips of 60 cycles, each short of the 100-cycle filter: together they would pass it
      repeat (2) begin
        set_raw(i, 1'b1);
        cyc(60);
        set_raw(i, 1'b0);
        cyc(2);
      end
      check("gate_output", 1'b1, gate_output);
      set_raw(i, 1'b1);
      cyc(102);
      check("gate_output", 1'b0, gate_output);
      check("power_good", 1'b0, power_good);
      check("sensed_pwm", 1'b0, sensed_pwm_output);
      set_raw(i, 1'b0);
      cyc(103);
      check("gate_output", 1'b1, gate_output);
    end
    $display("t_uvlo done");
  endtask

  task automatic t_open_clamp();
    vdd_open = 1'b1;
    #1;
    check("active_pulldown", 1'b1, gate_active_pulldown);
    check("power_good", 1'b0, power_good);
    cyc(1);
    check("gate_output", 1'b0, gate_output);
    vdd_open = 1'b0;
    in_pos = 1'b0;
    gate_below_clamp = 1'b1;
    cyc(2);
    check("miller_clamp", 1'b1, miller_clamp_enable);
    gate_below_clamp = 1'b0;
    in_pos = 1'b1;
    cyc(2);
    check("miller_clamp", 1'b0, miller_clamp_enable);
    check("gate_output", 1'b1, gate_output);
    $display("t_open_clamp done");
  endtask

  task automatic t_overcurrent();
    oc_level = 1'b1;
    cyc(1);
    check("gate_output", 1'b0, gate_output);
    check("mid_level", 1'b1, gate_mid_level);
    check("fault_report_n", 1'b0, fault_report_n);
    cyc(19);
    check("mid_level", 1'b1, gate_mid_level);
    cyc(1);
    check("mid_level", 1'b0, gate_mid_level);
    check("soft_sink", 1'b1, gate_soft_sink);
    gate_at_rail = 1'b1;
    cyc(1);
    check("soft_sink", 1'b0, gate_soft_sink);
    check("hard_sink", 1'b1, gate_hard_sink);
    check("gate_output", 1'b0, gate_output);
    oc_level = 1'b0;
    gate_at_rail = 1'b0;
    $display("t_overcurrent done");
  endtask

  // Pulse enable low for n cycles, then sample one edge after the rise
  task automatic low_pulse(input int n);
    enable_rst_n = 1'b0;
    cyc(n);
    enable_rst_n = 1'b1;
    cyc(1);
  endtask

  task automatic t_fault_reset();
    low_pulse(25);
    check("fault_report_n", 1'b0, fault_report_n);
    cyc(10);
    low_pulse(20);
    check("fault_report_n", 1'b0, fault_report_n);
    check("gate_output", 1'b0, gate_output);
    low_pulse(21);
    check("fault_report_n", 1'b1, fault_report_n);
    cyc(1);
    check("gate_output", 1'b1, gate_output);
    $display("t_fault_reset done");
  endtask

  task automatic t_disable();
    enable_rst_n = 1'b0;
    cyc(1);
    check("gate_output", 1'b0, gate_output);
    check("hard_sink", 1'b1, gate_hard_sink);
    check("mid_level", 1'b0, gate_mid_level);
    enable_rst_n = 1'b1;
    cyc(2);
    check("gate_output", 1'b1, gate_output);
    check("fault_report_n", 1'b1, fault_report_n);
    $display("t_disable done");
  endtask

  initial begin
    #200000;
    err_count++;
    test_done();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    {vcc_uvlo_raw, vdd_uvlo_raw, vdd_open, in_pos, in_neg, inputs_floating} = 6'h00;
    {gate_below_clamp, gate_at_rail, analog_sense_input, oc_level} = 4'h0;
    enable_rst_n = 1'b1;
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    t_lockout();
    t_drive();
    t_uvlo();
    t_open_clamp();
    t_overcurrent();
    t_fault_reset();
    t_disable();
    test_done();
  end
endmodule // gate_driver_protection_control_tb

//--- tb/gdp_host_model.sv
`timescale 1ns/1ps
// Host and switch side: pull-ups on the open-drain pins, sense pin and its comparator
module gdp_host_model (
  input  wire logic power_good_o,
  input  wire logic power_good_oe,
  input  wire logic fault_report_n_o,
  input  wire logic fault_report_n_oe,
  input  wire logic overcurrent_sense_o,
  input  wire logic overcurrent_sense_oe,
  input  wire logic oc_level,
  output logic      power_good,
  output logic      fault_report_n,
  output logic      overcurrent_sense_in,
  output logic      overcurrent_trip
);
  assign power_good = power_good_oe ? power_good_o : 1'b1;
  assign fault_report_n = fault_report_n_oe ? fault_report_n_o : 1'b1;
  // A pulled-down sense pin hides whatever the switch current would show
  assign overcurrent_sense_in = overcurrent_sense_oe ? overcurrent_sense_o : oc_level;
  assign overcurrent_trip = overcurrent_sense_in;
endmodule // gdp_host_model
